/* inc/rrb_map.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  resolver readout slave. Assumes a 50 MHz system clock.
*/
`ifndef RRB_MAP_SVH
`define RRB_MAP_SVH

// -----------------------------------------------------------------
// address space
// -----------------------------------------------------------------
`define RRB_ADR_W       16
`define RRB_SEL_BITS    14
`define RRB_LOW_BITS    2
`define RRB_OFS_CTRL    2'h0
`define RRB_OFS_ANGLE   2'h2
`define RRB_AM_SUP      6'h2D
`define RRB_AM_NPRIV    6'h29

// -----------------------------------------------------------------
// control / status word layout
// -----------------------------------------------------------------
`define RRB_CTL_GATE    0
`define RRB_CTL_CHAN    1
`define RRB_CTL_SINCOS  3
`define RRB_CTL_FAIL    4
`define RRB_CTL_MOD     5
`define RRB_ST_BUSY     8
`define RRB_ST_STROBE   9
`define RRB_CTL_RESET   8'h00
`define RRB_ANGLE_W     14

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define RRB_CLK_NS      20
`define RRB_STROBE_NS   2000
`define RRB_STROBE_CYC  ((`RRB_STROBE_NS + `RRB_CLK_NS - 1) / `RRB_CLK_NS)

`endif

/* inc/rrb_pkg.sv */
/*
  Types of the resolver readout slave: state records and the
  strobe sequencer states. Assumes rrb_map.svh for widths.
*/
package rrb_pkg;

  // strobe sequencer states
  typedef enum logic [0:0] {
    RRB_ST_IDLE  = 1'b0,
    RRB_ST_PULSE = 1'b1
  } rrb_strobe_state_t;

  // strobe generator state
  typedef struct packed {
    rrb_strobe_state_t phase;
    logic [7:0]        count;
    logic              strobe_n;
  } rrb_sgen_t;

  // address compare state
  typedef struct packed {
    logic       hit;
    logic [1:0] offset;
  } rrb_dec_t;

  // top level state
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [13:0] angle;
    logic        busy;
    logic        ack;
    logic [15:0] rdata;
    logic        xcvr_read_en;
    logic        mux_lo_n;
    logic        mux_hi_n;
    logic        sin_cos;
    logic        fail;
    logic        mux_short;
    logic        gate;
    logic [7:0]  mod_en_n;
  } rrb_top_t;

endpackage

/* logic/rrb_decode.sv */
/*
  Board select: compares the short I/O address against the board
  switches and checks the address modifier. Inputs are synchronous.
*/
`timescale 1ns/1ns
`include "rrb_map.svh"

module rrb_decode
  import rrb_pkg::*;
(
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // bus request
  input  wire logic                     req,
  input  wire logic [`RRB_ADR_W-1:0]    adr,
  input  wire logic [5:0]               am_code,
  // board configuration
  input  wire logic [1:0]               am_enable,
  input  wire logic [`RRB_SEL_BITS-1:0] board_switch,
  // result
  output logic                          hit,
  output logic [1:0]                    offset
);

  rrb_dec_t st;
  rrb_dec_t next_st;
  logic     am_ok;

  assign am_ok = (am_enable[0] && am_code == `RRB_AM_SUP) ||
                 (am_enable[1] && am_code == `RRB_AM_NPRIV);

  always_comb begin
    next_st        = st;
    next_st.hit    = req && am_ok && (adr[`RRB_ADR_W-1:`RRB_LOW_BITS] == board_switch);
    next_st.offset = adr[`RRB_LOW_BITS-1:0];
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hit    = st.hit;
  assign offset = st.offset;

endmodule

/* logic/rrb_sample_gen.sv */
/*
  Sample time generator: one active-low strobe per reference peak
  while the gate is high. Assumes ref_peak is a one-cycle pulse.
*/
`timescale 1ns/1ns
`include "rrb_map.svh"

module rrb_sample_gen
  import rrb_pkg::*;
#(
  parameter int STROBE_CYC = `RRB_STROBE_CYC
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // reference and gate
  input  wire logic ref_peak,
  input  wire logic sample_gate,
  // strobe out
  output logic      sample_strobe_n,
  output logic      strobe_active
);

  rrb_sgen_t st;
  rrb_sgen_t next_st;

  // peak start and pulse timing
  always_comb begin
    next_st = st;
    case (st.phase)
      RRB_ST_IDLE: begin
        if (ref_peak && sample_gate) begin
          next_st.phase    = RRB_ST_PULSE;
          next_st.count    = 8'(STROBE_CYC - 1);
          next_st.strobe_n = 1'b0;
        end
      end
      RRB_ST_PULSE: begin
        if (st.count == 8'h00) begin
          next_st.phase    = RRB_ST_IDLE;
          next_st.strobe_n = 1'b1;
        end else begin
          next_st.count = st.count - 8'h01;
        end
      end
      default: begin
        next_st.phase    = RRB_ST_IDLE;
        next_st.strobe_n = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '{phase: RRB_ST_IDLE, count: 8'h00, strobe_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign sample_strobe_n = st.strobe_n;
  assign strobe_active   = (st.phase == RRB_ST_PULSE);

endmodule

/* logic/rrb_top.sv */
/*
  Resolver readout bus slave: Wishbone classic register access to a
  control word and a held 14-bit shaft angle, plus the front-end
  controls (sample gate strobe, mux selects, sin/cos select, mux
  shorting). Assumes all inputs synchronous to clock, the converter
  busy input high while a conversion runs, ref_peak one cycle wide.
*/
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`include "rrb_map.svh"

// Operation
// - 16-bit data, transceivers read-enabled when selected
// - accept only modifier 2D or 29
// - switch compare asserts board select on match
// - selected read drives current angle word
// - 14-bit binary angle, bit 13 180 degrees
// - one internal bus for reads, control writes
// - control register drives converter and failure lamp
// - gate high gives strobe per peak
// - gate checked at start, strobe completes
// - all channels share one strobe per cycle
// - four channels per module, shared converter
// - two active-low lines pick channel
// - converter busy closes mux shorting switches
// - sin/cos select onto one line
// - four bytes, upper fourteen bits compared
module rrb_top
  import rrb_pkg::*;
#(
  parameter int NUM_MODULES = 1,
  parameter int STROBE_CYC  = `RRB_STROBE_CYC
)
(
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // wishbone slave
  input  wire logic                     wb_cyc,
  input  wire logic                     wb_stb,
  input  wire logic                     wb_we,
  input  wire logic [`RRB_ADR_W-1:0]    wb_adr,
  input  wire logic [1:0]               wb_sel,
  input  wire logic [15:0]              wb_dat_w,
  output logic      [15:0]              wb_dat_r,
  output logic                          wb_ack,
  // bus qualifiers and board setup
  input  wire logic [5:0]               am_code,
  input  wire logic [1:0]               am_enable,
  input  wire logic [`RRB_SEL_BITS-1:0] board_switch,
  output logic                          xcvr_read_en,
  // converter side
  input  wire logic [`RRB_ANGLE_W-1:0]  conv_angle,
  input  wire logic                     conv_busy,
  input  wire logic                     ref_peak,
  // front end controls
  output logic                          sample_strobe_n,
  output logic                          sample_gate,
  output logic                          mux_select_lo_n,
  output logic                          mux_select_hi_n,
  output logic [NUM_MODULES-1:0]        module_select_n,
  output logic                          sin_cos_sel,
  output logic                          mux_short,
  output logic                          failure_indicator
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  rrb_top_t    st;
  rrb_top_t    next_st;
  logic        req;
  logic        hit;
  logic [1:0]  offset;
  logic        strobe_active;
  logic [15:0] internal_data_bus;
  logic [7:0]  ctrl_merged;
  logic        ctrl_write;
  logic [7:0]  ctrl_next;
  logic [7:0]  mod_onehot_n;

  // -----------------------------------------------------------------
  // address compare
  // -----------------------------------------------------------------

  // request seen while the master holds cyc and stb
  assign req = wb_cyc && wb_stb;

  // board select and modifier qualify
  rrb_decode u_decode (
    .clock        (clock),
    .rst          (rst),
    .req          (req),
    .adr          (wb_adr),
    .am_code      (am_code),
    .am_enable    (am_enable),
    .board_switch (board_switch),
    .hit          (hit),
    .offset       (offset)
  );

  // -----------------------------------------------------------------
  // sample strobe
  // -----------------------------------------------------------------

  rrb_sample_gen #(
    .STROBE_CYC (STROBE_CYC)
  ) u_sample_gen (
    .clock           (clock),
    .rst             (rst),
    .ref_peak        (ref_peak),
    .sample_gate     (st.gate),
    .sample_strobe_n (sample_strobe_n),
    .strobe_active   (strobe_active)
  );

  // -----------------------------------------------------------------
  // control write path
  // -----------------------------------------------------------------

  always_comb begin
    ctrl_merged = st.ctrl;
    if (wb_sel[0]) begin
      ctrl_merged = wb_dat_w[7:0];   // high byte is status only
    end
  end

  // control word after this edge, kept apart from next_st to avoid a loop
  assign ctrl_write = req && hit && !st.ack && wb_we && (offset == `RRB_OFS_CTRL);
  assign ctrl_next  = ctrl_write ? ctrl_merged : st.ctrl;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mod
      assign mod_onehot_n[gi] = (ctrl_next[`RRB_CTL_MOD +: 3] != 3'(gi));
    end
  endgenerate

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------

  always_comb begin
    internal_data_bus = 16'h0000;
    case (offset)
      `RRB_OFS_CTRL: begin
        internal_data_bus[7:0]            = st.ctrl;
        internal_data_bus[`RRB_ST_BUSY]   = st.busy;
        internal_data_bus[`RRB_ST_STROBE] = strobe_active;
      end
      `RRB_OFS_ANGLE: begin
        internal_data_bus[`RRB_ANGLE_W-1:0] = st.angle;
      end
      default: begin
        internal_data_bus = 16'h0000;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------

  // bus handshake, control and converter tracking
  always_comb begin
    next_st = st;

    // single-cycle ack, dropped after one cycle
    next_st.ack = req && hit && !st.ack;

    next_st.xcvr_read_en = req && hit && !wb_we;

    if (req && hit && !st.ack && !wb_we) begin
      next_st.rdata = internal_data_bus;
    end else if (!req) begin
      next_st.rdata = 16'h0000;
    end

    // new control word, loaded at the ack edge
    next_st.ctrl = ctrl_next;

    next_st.busy = conv_busy;
    if (!conv_busy) begin
      next_st.angle = conv_angle;
    end

    next_st.mux_short = conv_busy;

    next_st.gate = next_st.ctrl[`RRB_CTL_GATE];
    next_st.mux_lo_n = !next_st.ctrl[`RRB_CTL_CHAN];
    next_st.mux_hi_n = !next_st.ctrl[`RRB_CTL_CHAN + 1];
    // sin or cos onto one line
    next_st.sin_cos  = next_st.ctrl[`RRB_CTL_SINCOS];
    next_st.fail     = next_st.ctrl[`RRB_CTL_FAIL];
    next_st.mod_en_n = mod_onehot_n;
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------

  // synchronous reset to idle, lamp off, gate closed
  always_ff @(posedge clock) begin
    if (rst) begin
      st          <= '0;
      st.ctrl     <= `RRB_CTL_RESET;
      st.mux_lo_n <= 1'b1;
      st.mux_hi_n <= 1'b1;
      st.mod_en_n <= 8'hFE;
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------

  // every output but sample_strobe_n taken straight from the state register
  assign wb_dat_r          = st.rdata;
  assign wb_ack            = st.ack;
  assign xcvr_read_en      = st.xcvr_read_en;
  assign sample_gate       = st.gate;
  assign mux_select_lo_n   = st.mux_lo_n;
  assign mux_select_hi_n   = st.mux_hi_n;
  assign module_select_n   = st.mod_en_n[NUM_MODULES-1:0];
  assign sin_cos_sel       = st.sin_cos;
  assign mux_short         = st.mux_short;
  assign failure_indicator = st.fail;

endmodule

/* tb/rrb_conv_model.sv */
/*
  Converter and reference model: peak pulses and a busy
  conversion. Assumes start is a one-cycle request.
*/
`timescale 1ns/1ns

module rrb_conv_model #(
  parameter int PERIOD = 12
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [13:0] target,
  output logic      [13:0] conv_angle,
  output logic             conv_busy,
  output logic             ref_peak
);
  logic [7:0] pc;
  logic [2:0] bc;

  // reference peaks and busy sequencing
  always_ff @(posedge clock) begin
    pc <= (rst || pc == PERIOD - 1) ? 8'h00 : pc + 8'h01;
    ref_peak <= !rst && pc == PERIOD - 1;
    if (rst) begin
      conv_busy <= 1'b0;
      bc <= 3'h0;
      conv_angle <= 14'h0000;
    end else if (start && !conv_busy) begin
      conv_busy <= 1'b1;
      bc <= 3'h6;
    end else if (conv_busy) begin
      bc <= bc - 3'h1;
      conv_angle <= conv_angle ^ 14'h1555;
      if (bc == 3'h0) begin
        conv_busy <= 1'b0;
        conv_angle <= target;
      end
    end
  end
endmodule

/* tb/rrb_top_sva.sv */
/*
  Port checker for the resolver readout slave.
  Assumes one idle cycle between bus requests.
*/
`timescale 1ns/1ns
`include "rrb_map.svh"

module rrb_top_sva
  import rrb_pkg::*;
#(
  parameter int STROBE_CYC = 4
)
(
  // clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // bus side
  input wire logic                     wb_cyc,
  input wire logic                     wb_stb,
  input wire logic                     wb_we,
  input wire logic [`RRB_ADR_W-1:0]    wb_adr,
  input wire logic [1:0]               wb_sel,
  input wire logic [15:0]              wb_dat_w,
  input wire logic [15:0]              wb_dat_r,
  input wire logic                     wb_ack,
  input wire logic [5:0]               am_code,
  input wire logic [1:0]               am_enable,
  input wire logic [`RRB_SEL_BITS-1:0] board_switch,
  input wire logic                     xcvr_read_en,
  // front end
  input wire logic                     conv_busy,
  input wire logic                     ref_peak,
  input wire logic                     sample_strobe_n,
  input wire logic                     sample_gate,
  input wire logic                     mux_select_lo_n,
  input wire logic                     failure_indicator,
  input wire logic                     mux_short
);
  logic [7:0] lo_cnt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // length of the current low strobe
  always_ff @(posedge clock) begin
    lo_cnt <= (rst || sample_strobe_n) ? 8'h00 : lo_cnt + 8'h01;
  end

  a_ack_single: assert property (wb_ack |=> !wb_ack) else $error("ack wider than one cycle");
  a_ack_latency: assert property (wb_ack |-> $past(wb_stb, 2) && !$past(wb_stb, 3))
    else $error("ack not two cycles after request");
  a_board_hit: assert property (wb_ack |-> wb_adr[15:2] == board_switch)
    else $error("ack for foreign address");
  a_modifier_ok: assert property (wb_ack |-> (am_code == 6'h2D && am_enable[0])
    || (am_code == 6'h29 && am_enable[1])) else $error("ack for refused modifier");
  a_xcvr_dir: assert property (wb_ack |-> xcvr_read_en == !wb_we)
    else $error("transceiver direction wrong");
  a_dat_idle: assert property (!wb_cyc && !$past(wb_cyc) |-> wb_dat_r == 16'h0000)
    else $error("read data driven while idle");
  a_ctrl_pins: assert property (wb_ack && wb_we && wb_adr[1:0] == 2'h0 && wb_sel[0]
    |=> sample_gate == $past(wb_dat_w[0]) && failure_indicator == $past(wb_dat_w[4])
    && mux_select_lo_n == !$past(wb_dat_w[1])) else $error("control outputs not loaded");
  a_strobe_start: assert property (ref_peak && sample_gate && sample_strobe_n |=> !sample_strobe_n)
    else $error("missing strobe");
  a_strobe_cause: assert property ($fell(sample_strobe_n) |-> $past(ref_peak) && $past(sample_gate))
    else $error("strobe without gated peak");
  a_strobe_width: assert property ($rose(sample_strobe_n) |-> lo_cnt == STROBE_CYC)
    else $error("strobe width wrong");
  a_short_busy: assert property (conv_busy |=> mux_short) else $error("shorting not closed");

  c_strobe: cover property ($fell(sample_strobe_n));
  c_read_busy: cover property (wb_ack && !wb_we && conv_busy);
  c_write: cover property (wb_ack && wb_we);
endmodule

/* tb/rrb_top_tb.sv */
/*
  Self-checking bench for rrb_top as sole bus master.
  Assumes the converter model for the analogue side.
*/
`timescale 1ns/1ns
`include "rrb_map.svh"

module rrb_top_tb
  import rrb_pkg::*;
;
  typedef struct packed {logic we; logic [1:0] ofs; logic [15:0] dat; logic [15:0] exp;} rrb_row_t;
  logic        clock, rst, wb_cyc, wb_stb, wb_we, wb_ack, start, ok, xcvr_read_en, conv_busy, ref_peak;
  logic        sample_strobe_n, sample_gate, mux_select_lo_n, mux_select_hi_n, sin_cos_sel, mux_short;
  logic        failure_indicator;
  logic [0:0]  module_select_n;
  logic [1:0]  wb_sel, am_enable;
  logic [5:0]  am_code;
  logic [13:0] board_switch, conv_angle, target;
  logic [15:0] wb_adr, wb_dat_w, wb_dat_r, rd;
  int          n_fail, comparisons, n;
  rrb_row_t    rows [6] = '{'{1'b1, 2'h0, 16'hFF1E, 16'h0}, '{1'b0, 2'h0, 16'h0, 16'h001E},
    '{1'b0, 2'h1, 16'h0, 16'h0}, '{1'b1, 2'h2, 16'h3FFF, 16'h0}, '{1'b0, 2'h2, 16'h0, 16'h0},
    '{1'b0, 2'h3, 16'h0, 16'h0}};

  rrb_top #(.NUM_MODULES(1), .STROBE_CYC(4)) dut (.clock, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .am_code, .am_enable, .board_switch, .xcvr_read_en,
    .conv_angle, .conv_busy, .ref_peak, .sample_strobe_n, .sample_gate, .mux_select_lo_n,
    .mux_select_hi_n, .module_select_n, .sin_cos_sel, .mux_short, .failure_indicator);
  rrb_conv_model #(.PERIOD(12)) conv (.clock, .rst, .start, .target, .conv_angle, .conv_busy, .ref_peak);

  // clock and strobe counter
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(negedge sample_strobe_n) n++;

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle, waits for ack
  task automatic bus(input logic we, input logic [1:0] sel, input logic [15:0] adr, input logic [15:0] dat);
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= sel;
    wb_adr <= adr;
    wb_dat_w <= dat;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clock);
      ok = (wb_ack === 1'b1);
      rd = wb_dat_r;
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    give_verdict();
  end

  // main sequence
  initial begin
    {rst, wb_cyc, wb_stb, wb_we, start} <= 5'b10000;
    {wb_sel, wb_adr, wb_dat_w, target} <= '0;
    am_code <= `RRB_AM_SUP;
    am_enable <= 2'b01;
    board_switch <= 14'h3FC0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("reset pins", {8'h0, module_select_n, sample_gate, failure_indicator, sin_cos_sel, mux_short,
      sample_strobe_n, mux_select_lo_n, mux_select_hi_n}, 16'h0007);
    $display("test reset done");
    foreach (rows[k]) begin
      bus(rows[k].we, 2'b11, {board_switch, rows[k].ofs}, rows[k].dat);
      check("ack", {15'h0, ok}, 16'h0001);
      if (!rows[k].we) check("read", rd, rows[k].exp);
    end
    check("ctrl pins", {12'h0, failure_indicator, sin_cos_sel, mux_select_hi_n, mux_select_lo_n}, 16'h000C);
    $display("test rows done");
    bus(1'b1, 2'b10, {board_switch, 2'h0}, 16'h00E1);
    bus(1'b0, 2'b11, {board_switch, 2'h0}, 16'h0);
    check("lane", rd, 16'h001E);
    bus(1'b0, 2'b11, {board_switch ^ 14'h0001, 2'h0}, 16'h0);
    check("foreign ack", {15'h0, ok}, 16'h0000);
    am_code <= `RRB_AM_NPRIV;
    bus(1'b0, 2'b11, {board_switch, 2'h0}, 16'h0);
    check("modifier off", {15'h0, ok}, 16'h0000);
    am_enable <= 2'b11;
    bus(1'b0, 2'b11, {board_switch, 2'h0}, 16'h0);
    check("modifier on", {15'h0, ok}, 16'h0001);
    $display("test select done");
    target <= 14'h2001;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    bus(1'b0, 2'b11, {board_switch, 2'h2}, 16'h0);
    check("held angle", rd, 16'h0000);
    repeat (10) @(posedge clock);
    bus(1'b0, 2'b11, {board_switch, 2'h2}, 16'h0);
    check("new angle", rd, 16'h2001);
    $display("test angle done");
    bus(1'b1, 2'b11, {board_switch, 2'h0}, 16'h0001);
    n = 0;
    repeat (36) @(posedge clock);
    check("strobes on", n[15:0], 16'h0003);
    bus(1'b1, 2'b11, {board_switch, 2'h0}, 16'h0000);
    repeat (6) @(posedge clock);
    n = 0;
    repeat (36) @(posedge clock);
    check("strobes off", n[15:0], 16'h0000);
    $display("test strobe done");
    bus(1'b1, 2'b11, {board_switch, 2'h0}, 16'h00F3);
    check("module sel", {15'h0, module_select_n}, 16'h0001);
    check("lamp on", {15'h0, failure_indicator}, 16'h0001);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("reset again", {8'h0, module_select_n, sample_gate, failure_indicator, sin_cos_sel, mux_short,
      sample_strobe_n, mux_select_lo_n, mux_select_hi_n}, 16'h0007);
    bus(1'b0, 2'b11, {board_switch, 2'h0}, 16'h0);
    check("ctrl after reset", rd, 16'h0000);
    $display("test reset again done");
    give_verdict();
  end
endmodule

bind rrb_top rrb_top_sva #(.STROBE_CYC(STROBE_CYC)) u_sva (.clock, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
  .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .am_code, .am_enable, .board_switch, .xcvr_read_en, .conv_busy,
  .ref_peak, .sample_strobe_n, .sample_gate, .mux_select_lo_n, .failure_indicator, .mux_short);
